// ===== rtl/pviu_consts.svh
// constants of the prioritised vectored interrupt unit
`ifndef PVIU_CONSTS_SVH
`define PVIU_CONSTS_SVH
// register byte offsets
`define PVIU_OFS_CTL0 8'h00
`define PVIU_OFS_CTL1 8'h04
`define PVIU_OFS_MISC 8'h08
`define PVIU_OFS_PIN 8'h0c
`define PVIU_OFS_STAT 8'h10
// irq_control_first fields
`define PVIU_B_GIE 0
`define PVIU_B_PIE 1
`define PVIU_B_T0E 2
`define PVIU_B_T1E 3
`define PVIU_B_PIF 4
`define PVIU_B_T0F 5
`define PVIU_B_T1F 6
`define PVIU_CTL0_MASK 8'h7f
// irq_control_second fields
`define PVIU_B_CVE 0
`define PVIU_B_TKE 1
`define PVIU_B_CVF 4
`define PVIU_B_TKF 5
`define PVIU_CTL1_MASK 8'h33
// misc_control_reg edge select field
`define PVIU_B_EDGE_LO 6
`define PVIU_B_EDGE_HI 7
`define PVIU_MISC_MASK 8'hc0
// pin configuration fields
`define PVIU_B_DIR 0
`define PVIU_B_PULL 1
`define PVIU_PIN_MASK 8'h03
// reset value of every register
`define PVIU_REG_RST 8'h00
// conversion source fitted
`define PVIU_HAS_CONV 1'b1
// vectors
`define PVIU_PC_W 10
`define PVIU_VEC_PIN 10'h004
`define PVIU_VEC_T0 10'h008
`define PVIU_VEC_T1 10'h00c
`define PVIU_VEC_CONV 10'h010
`define PVIU_VEC_TICK 10'h014
// return stack
`define PVIU_STK_DEPTH 8
`define PVIU_SP_W 4
// timing: last divider count of the four-clock instruction cycle, last wake count before the jump
`define PVIU_DIV_LAST 2'd3
`define PVIU_WAKE_LAST 2'd2
`endif

// ===== rtl/pviu_pkg.sv
// types of the prioritised vectored interrupt unit
`include "pviu_consts.svh"
package pviu_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_WAKE} pviu_fsm_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } pviu_avs_req_t;
   typedef struct packed {
      logic t0_ovf;
      logic t1_ovf;
      logic conv_done;
      logic tick;
   } pviu_evt_t;
   typedef struct packed {
      logic push;
      logic pop;
      logic [`PVIU_PC_W-1:0] pc;
   } pviu_core_req_t;
   typedef struct packed {
      logic jump;
      logic [`PVIU_PC_W-1:0] vec;
      logic ret_valid;
      logic [`PVIU_PC_W-1:0] ret_pc;
      logic full;
   } pviu_core_rsp_t;
   typedef struct packed {
      logic [7:0] ctl0;
      logic [7:0] ctl1;
      logic [7:0] misc;
      logic [7:0] pincfg;
      logic pin_prev;
      logic [1:0] div;
      logic t2;
      pviu_fsm_t st;
      logic [1:0] wcnt;
      logic [`PVIU_SP_W-1:0] sp;
      logic [`PVIU_STK_DEPTH-1:0][`PVIU_PC_W-1:0] stk;
      logic ack;
      logic [31:0] rdata;
      logic jump;
      logic [`PVIU_PC_W-1:0] vec;
      logic ret_valid;
      logic [`PVIU_PC_W-1:0] ret_pc;
   } pviu_state_t;
endpackage

// ===== rtl/pviu_top.sv
// prioritised vectored interrupt unit with return stack
`timescale 1ns/1ps
`default_nettype none
`include "pviu_consts.svh"

module pviu_top (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire pviu_pkg::pviu_avs_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // peripheral events, one-cycle pulses
   input wire pviu_pkg::pviu_evt_t evt,
   // shared port pin
   input wire logic pin_in,
   output logic pin_pull_en,
   output logic pin_is_irq,
   // core sequencer
   input wire pviu_pkg::pviu_core_req_t core_req,
   input wire logic core_sleep,
   output var pviu_pkg::pviu_core_rsp_t core_rsp,
   output logic core_wake,
   output logic phase_two_pulse
);
   import pviu_pkg::*;

   pviu_state_t q;
   pviu_state_t d;

   logic [4:0] pend;
   logic [4:0] en_pend;
   logic full;
   logic pin_sel;
   logic rise;
   logic fall;
   logic pin_edge;
   logic wr;
   logic jmp;
   logic [2:0] src;
   logic [31:0] rd_mux;

   // ----------------------------------------------------------
   // helpers
   // ----------------------------------------------------------

   // lowest index wins
   function automatic logic [2:0] prio(input logic [4:0] p);
      logic [2:0] r;
      r = 3'd0;
      for (int i = 4; i >= 0; i--) begin
         if (p[i]) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

   function automatic logic [`PVIU_PC_W-1:0] vec_of(input logic [2:0] s);
      logic [`PVIU_PC_W-1:0] v;
      case (s)
         3'd0: v = `PVIU_VEC_PIN;
         3'd1: v = `PVIU_VEC_T0;
         3'd2: v = `PVIU_VEC_T1;
         3'd3: v = `PVIU_VEC_CONV;
         default: v = `PVIU_VEC_TICK;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------
   // decode of the current state
   // ----------------------------------------------------------

   // pin mode: enable, edge chosen, direction input
   assign pin_sel = q.ctl0[`PVIU_B_PIE] & (q.misc[`PVIU_B_EDGE_HI] | q.misc[`PVIU_B_EDGE_LO])
      & q.pincfg[`PVIU_B_DIR];
   assign rise = pin_in & ~q.pin_prev;
   assign fall = ~pin_in & q.pin_prev;
   // edge select decode
   assign pin_edge = pin_sel & ((q.misc[`PVIU_B_EDGE_LO] & rise)
      | (q.misc[`PVIU_B_EDGE_HI] & fall));

   // pending sources in priority order, each with its own enable
   assign pend[0] = q.ctl0[`PVIU_B_PIF] & q.ctl0[`PVIU_B_PIE];
   assign pend[1] = q.ctl0[`PVIU_B_T0F] & q.ctl0[`PVIU_B_T0E];
   assign pend[2] = q.ctl0[`PVIU_B_T1F] & q.ctl0[`PVIU_B_T1E];
   assign pend[3] = q.ctl1[`PVIU_B_CVF] & q.ctl1[`PVIU_B_CVE] & `PVIU_HAS_CONV;
   assign pend[4] = q.ctl1[`PVIU_B_TKF] & q.ctl1[`PVIU_B_TKE];
   // global enable masks all jumps; core_wake and the sleep wake ignore it
   assign en_pend = pend & {5{q.ctl0[`PVIU_B_GIE]}};
   assign full = (q.sp == `PVIU_SP_W'(`PVIU_STK_DEPTH));
   assign src = prio(en_pend);

   // jump at a phase-two pulse, never into a full stack
   always_comb begin
      jmp = 1'b0;
      if (q.t2 & (|en_pend) & ~full) begin
         if (q.st == ST_WAIT) begin
            jmp = 1'b1;
         end else if (q.st == ST_WAKE && q.wcnt == `PVIU_WAKE_LAST) begin
            jmp = 1'b1;
         end
      end
   end

   // ----------------------------------------------------------
   // register bus
   // ----------------------------------------------------------

   // first cycle stalls, second answers
   assign avs_waitrequest = (avs_req.read | avs_req.write) & ~q.ack;
   assign wr = avs_req.write & q.ack;
   assign avs_readdata = q.rdata;

   // read data select
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (avs_req.address == `PVIU_OFS_CTL0) begin
         rd_mux[7:0] = q.ctl0 & `PVIU_CTL0_MASK;
      end else if (avs_req.address == `PVIU_OFS_CTL1) begin
         rd_mux[7:0] = q.ctl1 & `PVIU_CTL1_MASK;
      end else if (avs_req.address == `PVIU_OFS_MISC) begin
         rd_mux[7:0] = q.misc & `PVIU_MISC_MASK;
      end else if (avs_req.address == `PVIU_OFS_PIN) begin
         rd_mux[7:0] = q.pincfg & `PVIU_PIN_MASK;
      end else if (avs_req.address == `PVIU_OFS_STAT) begin
         rd_mux[7:0] = {2'b00, full, pin_sel, q.sp};
      end
   end

   // ----------------------------------------------------------
   // next state
   // ----------------------------------------------------------

   always_comb begin
      d = q;
      d.jump = 1'b0;
      d.ret_valid = 1'b0;
      d.t2 = 1'b0;
      d.pin_prev = pin_in;
      // instruction cycle divider
      if (q.div == `PVIU_DIV_LAST) begin
         d.div = 2'd0;
         d.t2 = 1'b1;
      end else begin
         d.div = q.div + 2'd1;
      end
      // bus handshake and read capture
      d.ack = (avs_req.read | avs_req.write) & ~q.ack;
      if (avs_req.read & ~q.ack) begin
         d.rdata = rd_mux;
      end
      // software writes
      if (wr) begin
         if (avs_req.address == `PVIU_OFS_CTL0) begin
            d.ctl0 = avs_req.writedata[7:0] & `PVIU_CTL0_MASK;
         end else if (avs_req.address == `PVIU_OFS_CTL1) begin
            d.ctl1 = avs_req.writedata[7:0] & `PVIU_CTL1_MASK;
         end else if (avs_req.address == `PVIU_OFS_MISC) begin
            d.misc = avs_req.writedata[7:0] & `PVIU_MISC_MASK;
         end else if (avs_req.address == `PVIU_OFS_PIN) begin
            d.pincfg = avs_req.writedata[7:0] & `PVIU_PIN_MASK;
         end
      end
      // sequencer
      case (q.st)
         ST_IDLE: begin
            d.wcnt = 2'd0;
            if (core_sleep & (|pend)) begin
               d.st = ST_WAKE;
            end else if (q.t2 & (|en_pend) & ~full) begin
               d.st = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (q.t2) begin
               d.st = ST_IDLE;
            end
         end
         default: begin
            if (q.t2) begin
               d.wcnt = q.wcnt + 2'd1;
               if (q.wcnt == `PVIU_WAKE_LAST) begin
                  d.st = ST_IDLE;
               end
            end
         end
      endcase
      // core stack traffic, held off while a jump pushes
      if (jmp) begin
         d.stk[q.sp[`PVIU_SP_W-2:0]] = core_req.pc;
         d.sp = q.sp + `PVIU_SP_W'(1);
         d.jump = 1'b1;
         d.vec = vec_of(src);
         d.ctl0[`PVIU_B_GIE] = 1'b0;
         // only the winner is cleared
         case (src)
            3'd0: d.ctl0[`PVIU_B_PIF] = 1'b0;
            3'd1: d.ctl0[`PVIU_B_T0F] = 1'b0;
            3'd2: d.ctl0[`PVIU_B_T1F] = 1'b0;
            3'd3: d.ctl1[`PVIU_B_CVF] = 1'b0;
            default: d.ctl1[`PVIU_B_TKF] = 1'b0;
         endcase
      end else if (core_req.push & ~full) begin
         d.stk[q.sp[`PVIU_SP_W-2:0]] = core_req.pc;
         d.sp = q.sp + `PVIU_SP_W'(1);
      end else if (core_req.pop & (q.sp != `PVIU_SP_W'(0))) begin
         d.ret_pc = q.stk[3'(q.sp - `PVIU_SP_W'(1))];
         d.sp = q.sp - `PVIU_SP_W'(1);
         d.ret_valid = 1'b1;
      end
      // hardware sets win over any clear, blocked or not
      if (pin_edge) begin
         d.ctl0[`PVIU_B_PIF] = 1'b1;
      end
      if (evt.t0_ovf) begin
         d.ctl0[`PVIU_B_T0F] = 1'b1;
      end
      if (evt.t1_ovf) begin
         d.ctl0[`PVIU_B_T1F] = 1'b1;
      end
      if (evt.conv_done & `PVIU_HAS_CONV) begin
         d.ctl1[`PVIU_B_CVF] = 1'b1;
      end
      if (evt.tick) begin
         d.ctl1[`PVIU_B_TKF] = 1'b1;
      end
   end

   // ----------------------------------------------------------
   // state register
   // ----------------------------------------------------------

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.ctl0 <= `PVIU_REG_RST;
         q.ctl1 <= `PVIU_REG_RST;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------
   // outputs
   // ----------------------------------------------------------

   // core answer
   always_comb begin
      core_rsp.jump = q.jump;
      core_rsp.vec = q.vec;
      core_rsp.ret_valid = q.ret_valid;
      core_rsp.ret_pc = q.ret_pc;
      core_rsp.full = full;
   end

   // pull-high kept whatever the pin mode
   assign pin_pull_en = q.pincfg[`PVIU_B_PULL];
   assign pin_is_irq = pin_sel;
   assign core_wake = |pend;
   assign phase_two_pulse = q.t2;

endmodule // pviu_top
`default_nettype wire

// ===== testbench/pviu_core_model.sv
// behavioural core sequencer facing the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pviu_core_model (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // unit answers and bench commands
   input wire pviu_pkg::pviu_core_rsp_t core_rsp,
   input wire logic call,
   input wire logic ret,
   // requests to the unit
   output var pviu_pkg::pviu_core_req_t core_req
);
   import pviu_pkg::*;
   // pc follows vectors, returns and calls; call and return are registered one clock late as push and pop
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         core_req <= '{push: 1'b0, pop: 1'b0, pc: 10'h100};
      end else begin
         core_req.push <= call;
         core_req.pop <= ret;
         if (core_rsp.jump) core_req.pc <= core_rsp.vec + 10'h1;
         else if (core_rsp.ret_valid) core_req.pc <= core_rsp.ret_pc;
         // advance on a registered push with no jump or return that clock, in the clock the unit stores the pre-call pc unless its stack is full or it jumps
         else if (core_req.push) core_req.pc <= core_req.pc + 10'h2;
      end
   end
endmodule // pviu_core_model
`default_nettype wire

// ===== testbench/pviu_top_sva.sv
// port assertions of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pviu_top_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // register bus
   input wire pviu_pkg::pviu_avs_req_t avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // events and pin
   input wire pviu_pkg::pviu_evt_t evt,
   input wire logic pin_in,
   input wire logic pin_pull_en,
   input wire logic pin_is_irq,
   // core side
   input wire pviu_pkg::pviu_core_req_t core_req,
   input wire logic core_sleep,
   input wire pviu_pkg::pviu_core_rsp_t core_rsp,
   input wire logic core_wake,
   input wire logic phase_two_pulse
);
   import pviu_pkg::*;
   // every check runs on the system clock, off during reset
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   chk_vec_table: assert property (
      core_rsp.jump |-> core_rsp.vec inside {10'h004, 10'h008, 10'h00c, 10'h010, 10'h014})
      else $error("jump to an unknown vector");
   chk_jump_phase: assert property (
      core_rsp.jump |-> $past(phase_two_pulse))
      else $error("jump not one clock after phase pulse");
   chk_phase_period: assert property (
      phase_two_pulse |=> !phase_two_pulse [*3] ##1 phase_two_pulse)
      else $error("instruction cycle is not four clocks");
   chk_full_refuse: assert property (
      core_rsp.jump |-> !$past(core_rsp.full))
      else $error("jump taken with stack full");
   chk_full_holds: assert property (
      core_rsp.full && !core_req.pop |=> core_rsp.full)
      else $error("full stack emptied without pop");
   chk_no_nest: assert property (
      core_rsp.jump |=> !core_rsp.jump [*4])
      else $error("second jump before enable restored");
   chk_ret_pop: assert property (
      core_rsp.ret_valid |-> $past(core_req.pop))
      else $error("return without pop");
   chk_bus_wait: assert property (
      (avs_req.read || avs_req.write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus wait longer than one cycle");
endmodule // pviu_top_sva
bind pviu_top pviu_top_sva pviu_top_sva_inst (.clk_sys, .rst, .avs_req, .avs_readdata,
   .avs_waitrequest, .evt, .pin_in, .pin_pull_en, .pin_is_irq, .core_req, .core_sleep,
   .core_rsp, .core_wake, .phase_two_pulse);
`default_nettype wire

// ===== testbench/pviu_top_tb.sv
// self-checking bench of the interrupt unit
`timescale 1ns/1ps
`default_nettype none
module pviu_top_tb;
   import pviu_pkg::*;
   logic clk_sys = 0, rst = 1, pin_in = 0, core_sleep = 0, call = 0, ret = 0;
   pviu_avs_req_t avs_req = '0;
   pviu_evt_t evt = '0;
   pviu_core_req_t core_req;
   pviu_core_rsp_t core_rsp;
   logic [31:0] avs_readdata, rd;
   logic avs_waitrequest, pin_pull_en, pin_is_irq, core_wake, phase_two_pulse;
   logic [9:0] saved_pc;
   int errors = 0, n_compared = 0;
   // 20 MHz clock
   always #25 clk_sys = ~clk_sys;
   pviu_top pviu_top_inst (.clk_sys, .rst, .avs_req, .avs_readdata, .avs_waitrequest, .evt,
      .pin_in, .pin_pull_en, .pin_is_irq, .core_req, .core_sleep, .core_rsp, .core_wake,
      .phase_two_pulse);
   pviu_core_model pviu_core_model_inst (.clk_sys, .rst, .core_rsp, .call, .ret, .core_req);
   // compare and count
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one bus access, held until waitrequest is low
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      avs_req <= '{read: !w, write: w, address: a, writedata: {24'h0, d}};
      do @(posedge clk_sys); while (avs_waitrequest);
      rd = avs_readdata;
      avs_req <= '0;
      @(posedge clk_sys);
   endtask
   // one-cycle event pulse
   task automatic ev(input pviu_evt_t e);
      evt <= e;
      @(posedge clk_sys);
      evt <= '0;
   endtask
   // wait for a jump and judge its delay and vector
   task automatic wj(input logic [9:0] v, input int lo, input int hi);
      int n;
      n = 0;
      saved_pc = core_req.pc;
      do begin
         @(posedge clk_sys);
         n++;
      end while (core_rsp.jump !== 1'b1 && n < 40);
      chk("jump delay", 1, n >= lo && n <= hi);
      if (v != 0) chk("vector", v, core_rsp.vec);
   endtask
   // return and judge the popped pc
   task automatic ret_chk(input logic [9:0] e);
      ret <= 1;
      @(posedge clk_sys);
      ret <= 0;
      repeat (2) @(posedge clk_sys);
      chk("return valid", 1, core_rsp.ret_valid);
      chk("return pc", e, core_rsp.ret_pc);
      @(posedge clk_sys);
   endtask
   // reset values, writable bits, read-only and unmapped places
   task automatic t_regs;
      logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};
      logic [7:0] m[6] = '{8'h7e, 8'h33, 8'hc0, 8'h03, 8'h00, 8'h00};
      // phase pulse repeats every four clocks
      do @(posedge clk_sys); while (phase_two_pulse !== 1'b1);
      repeat (3) begin
         @(posedge clk_sys);
         chk("phase gap", 0, phase_two_pulse);
      end
      @(posedge clk_sys);
      chk("phase pulse", 1, phase_two_pulse);
      for (int i = 0; i < 6; i++) begin
         bus(0, a[i], 0);
         chk("reset value", 0, rd);
         bus(1, a[i], i == 0 ? 8'hfe : 8'hff);
         bus(0, a[i], 0);
         chk("writable bits", m[i], rd);
         bus(1, a[i], 8'h00);
      end
   endtask
   // all timers, conversion and tick at once, served one by one
   task automatic t_prio;
      logic [9:0] v[4] = '{10'h008, 10'h00c, 10'h010, 10'h014};
      bus(1, 8'h04, 8'h03);
      bus(1, 8'h00, 8'h0d);
      ev('1);
      for (int i = 0; i < 4; i++) begin
         wj(v[i], 4, 13);
         bus(0, 8'h00, 0);
         chk("first control", i < 1 ? 32'h4c : 32'h0c, rd);
         bus(0, 8'h04, 0);
         chk("second control", 32'h03 | (i < 2 ? 32'h10 : 0) | (i < 3 ? 32'h20 : 0), rd);
         ret_chk(saved_pc);
         bus(1, 8'h00, i < 1 ? 8'h4d : 8'h0d);
      end
   endtask
   // global and own enable masking, flag kept
   task automatic t_mask;
      bus(1, 8'h00, 8'h08);
      ev(4'b0100);
      wj(0, 40, 40);
      bus(1, 8'h00, 8'h41);
      wj(0, 40, 40);
      bus(0, 8'h00, 0);
      chk("flag kept", 32'h41, rd);
      bus(1, 8'h00, 8'h49);
      wj(10'h00c, 1, 13);
      ret_chk(saved_pc);
   endtask
   // pin level change and resulting flag
   task automatic pin_edge(input logic lvl, input logic hit);
      pin_in <= lvl;
      repeat (2) @(posedge clk_sys);
      bus(0, 8'h00, 0);
      chk("pin flag", {hit, 4'h2}, rd);
      bus(1, 8'h00, 8'h02);
   endtask
   // edge modes, pin use and pin service
   task automatic t_pin;
      bus(1, 8'h0c, 8'h03);
      bus(1, 8'h00, 8'h02);
      for (int m = 0; m < 4; m++) begin
         bus(1, 8'h08, 8'(m << 6));
         chk("pin as irq", m != 0, pin_is_irq);
         chk("pull-high", 1, pin_pull_en);
         pin_edge(1, m[0]);
         pin_edge(0, m[1]);
      end
      bus(1, 8'h00, 8'h03);
      pin_in <= 1;
      wj(10'h004, 1, 16);
      bus(0, 8'h00, 0);
      chk("pin flag served", 32'h02, rd);
      ret_chk(saved_pc);
      bus(1, 8'h0c, 8'h02);
      chk("pin as output", 0, pin_is_irq);
   endtask
   // full stack refuses until a pop
   task automatic t_stack;
      for (int i = 0; i < 8; i++) begin
         call <= 1;
         @(posedge clk_sys);
         call <= 0;
         @(posedge clk_sys);
      end
      @(posedge clk_sys);
      chk("stack full", 1, core_rsp.full);
      bus(1, 8'h04, 8'h02);
      bus(1, 8'h00, 8'h01);
      ev(4'b0001);
      wj(0, 40, 40);
      ret_chk(saved_pc - 10'd2);
      wj(10'h014, 1, 16);
      ret_chk(saved_pc);
   endtask
   // wake from sleep then jump
   task automatic t_sleep;
      bus(1, 8'h00, 8'h05);
      core_sleep <= 1;
      ev(4'b1000);
      @(posedge clk_sys);
      chk("wake", 1, core_wake);
      wj(10'h008, 6, 13);
      core_sleep <= 0;
      ret_chk(saved_pc);
   endtask
   // verdict and end of run
   task automatic give_verdict;
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge clk_sys);
      rst <= 0;
      @(posedge clk_sys);
      t_regs();
      t_prio();
      t_mask();
      t_pin();
      t_stack();
      t_sleep();
      give_verdict();
   end
   // watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #1000000;
      errors++;
      give_verdict();
   end
endmodule // pviu_top_tb
`default_nettype wire
